/* rtl/interrupt_priority_field_bank.sv */
// Purpose: Bank of interrupt priority control registers on APB
// Assumes: Single clock; APB master follows protocol
// Notes: Zero wait states; unmapped addresses answer with pslverr
//
// Local design decisions: the APB register port and the placing of the registers.
`include "ipc_bank_map.svh"

module interrupt_priority_field_bank #(
    parameter int NUM_REGS = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output ipc_bank_pkg::priority_level_t slotPriority [NUM_REGS*4],
    output ipc_bank_pkg::subpriority_level_t slotSubpriority [NUM_REGS*4],
    output logic [NUM_REGS*4-1:0] slotEnabled
);
    import ipc_bank_pkg::*;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    localparam int IDX_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

    slot_field_t fields [NUM_REGS*4];
    logic [11:0] relAddr;
    logic hit;
    logic [IDX_W-1:0] regIdx;
    logic setup;
    bus_phase_t phase;

    assign relAddr = paddr - `IPC_BANK_BASE;
    assign hit = (relAddr[1:0] == 2'b00) &&
                 (relAddr[11:2] < 10'(NUM_REGS));
    assign regIdx = IDX_W'(relAddr[11:2]);
    assign setup = psel && !penable;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= BUS_IDLE;
        end else begin
            case (phase)
                BUS_IDLE: phase <= setup ? BUS_ACCESS : BUS_IDLE;
                BUS_ACCESS: phase <= BUS_IDLE;
                default: phase <= BUS_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    // Ready is registered so the output comes from a flop; one wait cycle never occurs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit;
        end
    end

    // Read word assembled at setup so it stands during the access phase
    logic [31:0] readWord;
    always_comb begin
        readWord = 32'h0000_0000;
        for (int s = 0; s < 4; s++) begin
            // Gap bits stay zero from the initial value
            readWord[s*`IPC_SLOT_STRIDE +: 5] = fields[int'(regIdx)*4 + s];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= (hit && !pwrite) ? readWord : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Field storage
    // ----------------------------------------
    logic doWrite;
    assign doWrite = psel && penable && pready && pwrite && hit;

    for (genvar g = 0; g < NUM_REGS*4; g++) begin : g_slot
        localparam int LANE = g % 4;
        localparam int REG = g / 4;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                fields[g] <= `IPC_FIELD_RESET;
            end else if (doWrite && int'(regIdx) == REG && pstrb[LANE]) begin
                // Only bits 4..0 of each byte lane stored
                fields[g].pri <= pwdata[LANE*`IPC_SLOT_STRIDE + `IPC_PRI_LSB +: 3];
                fields[g].sub <= pwdata[LANE*`IPC_SLOT_STRIDE + `IPC_SUB_LSB +: 2];
            end
        end
        // Outputs straight from flops; level seven highest, zero off
        assign slotPriority[g] = fields[g].pri;
        assign slotSubpriority[g] = fields[g].sub;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                slotEnabled[g] <= 1'b0;
            end else if (doWrite && int'(regIdx) == REG && pstrb[LANE]) begin
                slotEnabled[g] <= |pwdata[LANE*`IPC_SLOT_STRIDE + `IPC_PRI_LSB +: 3];
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_read_gap_zero: assert property (pready && !pwrite |->
        (prdata & 32'hE0E0_E0E0) == 32'h0000_0000)
        else $error("Reserved bits read nonzero");
    a_slot3_layout: assert property (doWrite && regIdx == '0 && pstrb[3] |=>
        slotPriority[3] == $past(pwdata[28:26]) && slotSubpriority[3] == $past(pwdata[25:24]))
        else $error("Slot 3 field layout wrong");
    a_slot2_layout: assert property (doWrite && regIdx == '0 && pstrb[2] |=>
        slotPriority[2] == $past(pwdata[20:18]) && slotSubpriority[2] == $past(pwdata[17:16]))
        else $error("Slot 2 field layout wrong");
    a_slot1_layout: assert property (doWrite && regIdx == '0 && pstrb[1] |=>
        slotPriority[1] == $past(pwdata[12:10]) && slotSubpriority[1] == $past(pwdata[9:8]))
        else $error("Slot 1 field layout wrong");
    a_slot0_layout: assert property (doWrite && regIdx == '0 && pstrb[0] |=>
        slotPriority[0] == $past(pwdata[4:2]) && slotSubpriority[0] == $past(pwdata[1:0]))
        else $error("Slot 0 field layout wrong");
    a_enable_zero: assert property ((slotPriority[0] == 3'h0) == !slotEnabled[0])
        else $error("Enable disagrees with priority");
    a_sub_held: assert property (!doWrite |=> $stable(slotSubpriority[1]))
        else $error("Subpriority changed without write");
    a_answer_one: assert property (setup |=> pready ##1 !pready)
        else $error("Answer not one cycle");
    a_readback: assert property (setup && hit && !pwrite && regIdx == '0 |=>
        prdata[28:24] == {slotPriority[3], slotSubpriority[3]})
        else $error("Readback mismatch");

    c_write_hit: cover property (doWrite);
    c_read_hit: cover property (pready && !pwrite && !pslverr);
    c_unmapped: cover property (pready && pslverr);
    c_top_level: cover property (slotPriority[3] == 3'h7 && slotSubpriority[3] == 2'h3);
endmodule // interrupt_priority_field_bank

/* rtl/ipc_bank_map.svh */
// Purpose: Offsets, field positions and reset values of the priority control bank
// Assumes: 32-bit APB, one aligned word per register
// Notes: Bank base and register count are choices of this block
`ifndef IPC_BANK_MAP_SVH
`define IPC_BANK_MAP_SVH

`define IPC_BANK_BASE 12'h000
`define IPC_REG_STRIDE 12'h004
`define IPC_SLOT_STRIDE 8
`define IPC_PRI_LSB 2
`define IPC_SUB_LSB 0
`define IPC_RESET_VALUE 32'h0000_0000
`define IPC_FIELD_RESET 5'h00

`endif

/* rtl/ipc_bank_pkg.sv */
// Purpose: Types of the priority control bank
// Assumes: Nothing beyond the header
// Notes: Field order in the slot type matches the bit layout
package ipc_bank_pkg;
    typedef logic [2:0] priority_level_t;
    typedef logic [1:0] subpriority_level_t;
    typedef struct packed {
        priority_level_t pri;
        subpriority_level_t sub;
    } slot_field_t;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACCESS = 1'b1
    } bus_phase_t;
endpackage

/* bench/testbench.sv */
// Purpose: Self-checking bench for the interrupt priority field bank
// Assumes: Zero-wait APB slave, four registers at 12'h000..12'h00C
// Notes: Assertions live in the design files; no checker here
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
    import ipc_bank_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [15:0] slotEnabled;
    priority_level_t slotPriority [16];
    subpriority_level_t slotSubpriority [16];
    logic [2:0] ep [4] = '{3'h1, 3'h7, 3'h4, 3'h2};
    logic [1:0] es [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
    int error_cnt = 0, compares = 0;
    interrupt_priority_field_bank #(.NUM_REGS(4)) dut_u (.clk(clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slotPriority(slotPriority), .slotSubpriority(slotSubpriority),
        .slotEnabled(slotEnabled));
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) error_cnt++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge lets the slot outputs settle before any check
        @(posedge clk);
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        error_cnt++;
        complete_run();
    end
    initial begin
        arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'hF;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0000_0000, 4'hF);
            `CHK("reset word", 32'h0000_0000, r)
        end
        `CHK("reset enables", 16'h0000, slotEnabled)
        apb(1'b1, 12'h000, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, 12'h000, 32'h0000_0000, 4'hF);
        `CHK("gap bits", 32'h1F1F_1F1F, r)
        // Distinct value per slot catches swapped lanes or fields
        apb(1'b1, 12'h004, 32'h0B12_1D05, 4'hF);
        apb(1'b0, 12'h004, 32'h0000_0000, 4'hF);
        `CHK("word1", 32'h0B12_1D05, r)
        for (int k = 0; k < 4; k++) begin
            `CHK("level", ep[k], slotPriority[4 + k])
            `CHK("sublevel", es[k], slotSubpriority[4 + k])
            `CHK("max level", 3'h7, slotPriority[k])
        end
        apb(1'b1, 12'h004, 32'h0000_0000, 4'h1);
        apb(1'b0, 12'h004, 32'h0000_0000, 4'hF);
        `CHK("strobe", 32'h0B12_1D00, r)
        `CHK("slot off", 2'b10, slotEnabled[5:4])
        apb(1'b1, 12'h00C, 32'h0000_0003, 4'hF);
        `CHK("zero level", 1'b0, slotEnabled[12])
        `CHK("sub kept", 2'h3, slotSubpriority[12])
        apb(1'b1, 12'h010, 32'hFFFF_FFFF, 4'hF);
        `CHK("unmapped err", 1'b1, e)
        apb(1'b0, 12'h002, 32'h0000_0000, 4'hF);
        `CHK("misaligned err", 1'b1, e)
        `CHK("misaligned data", 32'h0000_0000, r)
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h004, 32'h0000_0000, 4'hF);
        `CHK("second reset", 32'h0000_0000, r)
        complete_run();
    end
endmodule // testbench
